/* File: src/char_pos_pkg.sv */
// Shared constants and carriers for the character position decoder.
// Assumes a 32-bit APB slave with 12-bit byte addresses; element one in bit 0.
package char_pos_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses, one aligned word each)
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STAT_OFS   = 12'h004;
    localparam logic [11:0] COUNT_OFS  = 12'h008;

    // Control field positions and value after reset
    localparam int          CTRL_FOS   = 0;     // Function only state
    localparam int          CTRL_ARF   = 1;     // Return-and-feed bar
    localparam int          CTRL_SHF   = 2;     // Shift-unshift bar
    localparam int          CTRL_SUP   = 3;     // Suppression bar
    localparam logic [3:0]  CTRL_RST   = 4'h8;

    // Status field positions
    localparam int          STAT_POS   = 9;     // Decoded position, 6 bits
    localparam int          STAT_BUSY  = 15;

    ////////////////////////////////////////////////////////////////////////
    // Bar layout: bit set means the bar sits left (marking)
    localparam int          NUM_ELEM   = 5;
    localparam int          NUM_BARS   = 9;
    localparam int          BAR_COMMON = 5;
    localparam int          BAR_SUP    = 6;
    localparam int          BAR_ARF    = 7;
    localparam int          BAR_SHF    = 8;
    localparam logic [8:0]  BARS_RST   = 9'h040;

    // Case-change code combinations
    localparam logic [4:0]  ALPHA_CODE = 5'h1F;
    localparam logic [4:0]  SYMBOL_CODE = 5'h1B;

    // Cycles of one function or print revolution
    localparam int          REV_CYCLES = 4;

    ////////////////////////////////////////////////////////////////////////
    typedef logic [NUM_ELEM-1:0] code_type;
    typedef logic [NUM_BARS-1:0] bars_type;

    typedef struct packed {
        logic       half;   // 0 alpha half, 1 symbol half
        logic [1:0] row;
        logic       dir;    // 1 left of centre line
        logic [1:0] col;
    } pos_type;

endpackage : char_pos_pkg

/* File: src/char_pos_decoder.sv */
// Character position decoder: bars, position decode, print sequencing.
// Assumes a same-clock selector handing over characters by valid/ready,
// and an APB master on MCLK.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps

module char_pos_decoder #(
    parameter int REV = char_pos_pkg::REV_CYCLES
) (
    // Clock and reset
    input  wire logic                 MCLK,
    input  wire logic                 SYS_RST,
    // APB slave
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [11:0]          PADDR,
    input  wire logic [31:0]          PWDATA,
    output logic                      PREADY,
    output logic                      PSLVERR,
    output logic [31:0]               PRDATA,
    // Character stream from the selector
    input  wire logic                 CHAR_VALID,
    input  wire char_pos_pkg::code_type CHAR_CODE,
    output logic                      CHAR_READY,
    // Decoded position and cycles
    output char_pos_pkg::pos_type     POS,
    output logic                      POS_VALID,
    output char_pos_pkg::bars_type    BARS,
    output logic                      FUNC_CYCLE,
    output logic                      PRINT_CYCLE
);
    import char_pos_pkg::*;

    typedef enum logic [1:0] {IDLE, UPDATE, FUNC_GO, RUN} state_type;

    state_type  state_reg, state_next;
    logic [3:0] ctrl_reg;
    logic [31:0] count_reg;
    logic [7:0] rev_reg;
    logic       fos_run_reg;
    logic       ready_reg;
    code_type   fifo_reg [2];
    logic       wr_ptr_reg, rd_ptr_reg;
    logic [1:0] fill_reg;
    code_type   code_reg;

    ////////////////////////////////////////////////////////////////////////
    // Two-entry buffer; a busy decoder stalls the selector, nothing lost
    wire        push    = CHAR_VALID && ready_reg;
    wire        out_vld = fill_reg != 2'h0;
    wire        pop     = out_vld && (state_reg == IDLE);
    wire [1:0]  fill_next = fill_reg + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fill_reg   <= 2'h0;
            ready_reg  <= 1'b0;
        end else begin
            if (push) begin
                fifo_reg[wr_ptr_reg] <= CHAR_CODE;
                wr_ptr_reg           <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            fill_reg  <= fill_next;
            ready_reg <= fill_next != 2'h2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bar states; the five selecting elements and the suppression, return-and-feed and shift control bits reach the bars
    bars_type bar_next;
    pos_type  pos_next;
    wire      half_next;

    assign bar_next[NUM_ELEM-1:0] = code_reg;
    assign bar_next[BAR_COMMON]   = code_reg[0] | code_reg[1];
    assign bar_next[BAR_SUP]      = ctrl_reg[CTRL_SUP];
    assign bar_next[BAR_ARF]      = ctrl_reg[CTRL_ARF];
    assign bar_next[BAR_SHF]      = ctrl_reg[CTRL_SHF];

    // Case codes switch halves; any other code keeps the current half
    assign half_next = (code_reg == ALPHA_CODE)  ? 1'b0 :
                       (code_reg == SYMBOL_CODE) ? 1'b1 : POS.half;

    // Row stop: the first spacing bar of common, two, one blocks the
    // lever; with all marking the lever stops at the bottom row, 3
    wire [1:0] row_stop = !bar_next[BAR_COMMON] ? 2'h0 :
                          !bar_next[1]          ? 2'h1 :
                          !bar_next[0]          ? 2'h2 : 2'h3;

    assign pos_next.half = half_next;
    assign pos_next.row  = row_stop;
    assign pos_next.dir  = bar_next[2];
    assign pos_next.col  = {bar_next[3], bar_next[4]};

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: update once, start function, then print one cycle later
    // Function ends at count REV, print one count later, then back to idle
    wire rev_last = rev_reg == 8'(REV);
    wire rev_done = rev_reg == 8'(REV + 1);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IDLE:    if (pop) state_next = UPDATE;
            UPDATE:  state_next = FUNC_GO;
            FUNC_GO: state_next = RUN;
            RUN:     if (rev_done) state_next = IDLE;
        endcase
    end

    // Code capture and state register
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_reg <= IDLE;
            code_reg  <= '0;
        end else begin
            state_reg <= state_next;
            if (pop)
                code_reg <= fifo_reg[rd_ptr_reg];
        end
    end

    // Bars and position change only in the update state, then hold
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            BARS      <= BARS_RST;
            POS       <= '0;
            POS_VALID <= 1'b0;
        end else begin
            if (state_reg == UPDATE) begin
                BARS <= bar_next;
                POS  <= pos_next;
            end
            POS_VALID <= state_reg == UPDATE;
        end
    end

    // Revolution counter; print runs REV cycles, one behind function
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            rev_reg     <= 8'h00;
            fos_run_reg <= 1'b0;
            FUNC_CYCLE  <= 1'b0;
            PRINT_CYCLE <= 1'b0;
        end else begin
            if (state_reg == UPDATE) begin
                fos_run_reg <= ctrl_reg[CTRL_FOS];
                FUNC_CYCLE  <= 1'b1;
                rev_reg     <= 8'h01;
            end else if (state_reg != IDLE && !rev_done) begin
                rev_reg <= rev_reg + 8'h01;
            end
            if (rev_last && state_reg != UPDATE)
                FUNC_CYCLE <= 1'b0;
            if (state_reg == FUNC_GO)
                PRINT_CYCLE <= !fos_run_reg;
            else if (rev_done)
                PRINT_CYCLE <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode; one wait state, unmapped addresses answer with an error
    wire acc     = PSEL && PENABLE && !PREADY;
    wire hit_ctl = PADDR == CTRL_OFS;
    wire hit_st  = PADDR == STAT_OFS;
    wire hit_cnt = PADDR == COUNT_OFS;
    wire mapped  = hit_ctl || hit_st || hit_cnt;
    wire busy    = state_reg != IDLE;
    // Writes land at the edge that completes the access, as the master sees it
    wire wr_done = PSEL && PENABLE && PREADY && PWRITE;

    wire [31:0] rd_mux =
        hit_ctl ? {28'h0, ctrl_reg} :
        hit_st  ? {16'h0, busy, POS, BARS} :
        hit_cnt ? count_reg : 32'h0;

    // Bus answer and control register
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PREADY   <= 1'b0;
            PSLVERR  <= 1'b0;
            PRDATA   <= 32'h0;
            ctrl_reg <= CTRL_RST;
        end else begin
            PREADY  <= acc;
            PSLVERR <= acc && !mapped;
            PRDATA  <= (acc && !PWRITE) ? rd_mux : 32'h0;
            if (wr_done && hit_ctl)
                ctrl_reg <= PWDATA[3:0];
        end
    end

    // Printed character count; a write of any value clears it
    always_ff @(posedge MCLK) begin
        if (SYS_RST)
            count_reg <= 32'h0;
        else if (wr_done && hit_cnt)
            count_reg <= 32'h0;
        else if (state_reg == FUNC_GO && !fos_run_reg)
            count_reg <= count_reg + 32'h1;
    end

    assign CHAR_READY = ready_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    logic [7:0] func_len_reg;
    always_ff @(posedge MCLK) begin
        if (SYS_RST || !FUNC_CYCLE)
            func_len_reg <= 8'h00;
        else
            func_len_reg <= func_len_reg + 8'h01;
    end

    sequence s_update;
        state_reg == UPDATE;
    endsequence
    sequence s_func_start;
        $rose(FUNC_CYCLE) ##1 1'b1;
    endsequence

    property p_common;
        POS_VALID |-> BARS[BAR_COMMON] == (BARS[0] | BARS[1]);
    endproperty
    a_common: assert property (p_common) else $error("common bar wrong");

    property p_row;
        POS_VALID |-> POS.row == {BARS[1], BARS[0]};
    endproperty
    a_row: assert property (p_row) else $error("row decode wrong");

    property p_dir_col;
        POS_VALID |-> POS.dir == BARS[2] && POS.col == {BARS[3], BARS[4]};
    endproperty
    a_dir_col: assert property (p_dir_col) else $error("column decode wrong");

    property p_once;
        s_update |=> state_reg != UPDATE ##1 state_reg != UPDATE;
    endproperty
    a_once: assert property (p_once) else $error("update repeated");

    property p_hold;
        state_reg != UPDATE |=> $stable(BARS) && $stable(POS);
    endproperty
    a_hold: assert property (p_hold) else $error("bars moved outside update");

    property p_strobe;
        s_update |=> POS_VALID ##1 !POS_VALID;
    endproperty
    a_strobe: assert property (p_strobe) else $error("valid strobe wrong");

    property p_print_follows;
        s_func_start |-> PRINT_CYCLE == !fos_run_reg;
    endproperty
    a_print_follows: assert property (p_print_follows) else $error("print start wrong");

    property p_suppress;
        fos_run_reg && state_reg != UPDATE |-> !PRINT_CYCLE;
    endproperty
    a_suppress: assert property (p_suppress) else $error("printed in function only");

    property p_func_len;
        $fell(FUNC_CYCLE) |-> $past(func_len_reg) == 8'(REV) - 8'h01;
    endproperty
    a_func_len: assert property (p_func_len) else $error("function cycle length");

    property p_alpha;
        s_update ##0 code_reg == ALPHA_CODE |=> !POS.half;
    endproperty
    a_alpha: assert property (p_alpha) else $error("alpha half not chosen");

    property p_symbol;
        s_update ##0 code_reg == SYMBOL_CODE |=> POS.half;
    endproperty
    a_symbol: assert property (p_symbol) else $error("symbol half not chosen");

    property p_ready_full;
        fill_reg == 2'h2 |-> !CHAR_READY;
    endproperty
    a_ready_full: assert property (p_ready_full) else $error("ready while full");

endmodule : char_pos_decoder

/* File: src/char_pos_unused_guard.sv */
// Holds no logic; the whole decoder lives in char_pos_decoder.sv.

/* File: bench/char_selector_model.sv */
// Selector model: hands queued five-element codes to the decoder by valid/ready.
// Assumes the decoder's MCLK domain and its synchronous active-high reset.
`timescale 1ns/100ps

module char_selector_model (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Handshake towards the decoder
    input  wire logic             ready,
    output logic                  valid,
    output char_pos_pkg::code_type code
);
    import char_pos_pkg::*;

    code_type q[$];
    int       gap      = 0;     // Idle cycles after each code, set by the bench
    int       wait_cnt = 0;

    initial begin
        valid = 1'b0;
        code  = '0;
    end

    // Offer the next code; a released bus shows a changing pattern, not the last code
    always @(posedge clk) begin
        if (rst) begin
            valid <= 1'b0;
        end else if (!valid || ready) begin
            if (q.size() > 0 && wait_cnt == 0) begin
                valid <= 1'b1;
                code  <= q.pop_front();
                wait_cnt = gap;
            end else begin
                valid <= 1'b0;
                code  <= ~code;
                if (wait_cnt > 0) wait_cnt = wait_cnt - 1;
            end
        end
    end
endmodule : char_selector_model

/* File: bench/test_character_position_decoder.sv */
// Self-checking bench for the character position decoder.
// Assumes the selector model beside it and an APB master driven from here.
`timescale 1ns/100ps

module test_character_position_decoder;
    import char_pos_pkg::*;

    localparam int REV_T = 2;   // Short revolution keeps the run brief
    typedef struct packed { code_type code; logic [4:0] pos; } row_type;
    typedef struct packed { logic hc; logic [5:0] pos; bars_type bars; } exp_type;

    logic        MCLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic        CHAR_VALID, CHAR_READY, POS_VALID, FUNC_CYCLE, PRINT_CYCLE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    code_type    CHAR_CODE;
    pos_type     POS, pos_last;
    bars_type    BARS;
    exp_type     exp_q[$];
    exp_type     e;
    logic        half_exp = 0, pv_d = 0, full_seen = 0;
    logic [3:0]  ctrl_now = 4'h8;
    int          num_errors = 0, checks_done = 0, flen = 0, plen = 0;
    int          nfunc = 0, nprint = 0, npush = 0, nexp_print = 0;
    // Rows: code, expected {row, direction, column}
    row_type     rows[8] = '{'{5'h00, 5'h00}, '{5'h01, 5'h08}, '{5'h02, 5'h10},
                             '{5'h03, 5'h18}, '{5'h04, 5'h04}, '{5'h08, 5'h02},
                             '{5'h10, 5'h01}, '{5'h1D, 5'h0F}};

    char_pos_decoder #(.REV(REV_T)) dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .CHAR_VALID(CHAR_VALID),
        .CHAR_CODE(CHAR_CODE), .CHAR_READY(CHAR_READY), .POS(POS), .POS_VALID(POS_VALID),
        .BARS(BARS), .FUNC_CYCLE(FUNC_CYCLE), .PRINT_CYCLE(PRINT_CYCLE));

    char_selector_model sel (.clk(MCLK), .rst(SYS_RST), .ready(CHAR_READY),
        .valid(CHAR_VALID), .code(CHAR_CODE));

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : chk

    // One APB transfer; request held until PREADY is seen at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        PSEL    <= 1'b1;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        chk(n < 50, 1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask : apb

    // Queue a code with its expected position; bars follow the control bits
    task push(input code_type c, input logic [4:0] p);
        if (c == ALPHA_CODE) half_exp = 0;
        else if (c == SYMBOL_CODE) half_exp = 1;
        exp_q.push_back({c != ALPHA_CODE && c != SYMBOL_CODE, half_exp, p,
                         ctrl_now[2], ctrl_now[1], ctrl_now[3], c[0] | c[1], c});
        npush++;
        if (!ctrl_now[0]) nexp_print++;
        sel.q.push_back(c);
    endtask : push

    task drain;
        int n;
        n = 0;
        while ((exp_q.size() > 0 || sel.q.size() > 0 || FUNC_CYCLE || PRINT_CYCLE)
               && n < 500) begin
            @(posedge MCLK);
            n++;
        end
        chk(n < 500, 1);
        repeat (2) @(posedge MCLK);
    endtask : drain

    task close_out;
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////
    // Score each strobe and time the function and print revolutions
    always @(posedge MCLK) begin
        if (!SYS_RST) begin
            if (CHAR_VALID && !CHAR_READY) full_seen = 1;
            if (POS_VALID) begin
                chk(exp_q.size() > 0 && !pv_d, 1);
                if (exp_q.size() > 0) begin
                    e = exp_q.pop_front();
                    chk(BARS, e.bars);
                    chk(POS[4:0], e.pos[4:0]);
                    if (e.hc) chk(POS[5], e.pos[5]);
                end
            end else chk(POS, pos_last);
            if (PRINT_CYCLE && plen == 0) chk(flen, 1);
            if (!FUNC_CYCLE && flen > 0) begin
                chk(flen, REV_T);
                nfunc++;
            end
            if (!PRINT_CYCLE && plen > 0) begin
                chk(plen, REV_T);
                nprint++;
            end
            flen = FUNC_CYCLE ? flen + 1 : 0;
            plen = PRINT_CYCLE ? plen + 1 : 0;
        end
        pv_d = POS_VALID;
        pos_last = POS;
    end

    initial begin
        MCLK = 0;
        forever #20 MCLK = ~MCLK;
    end

    // Watchdog for a hung handshake
    initial begin
        repeat (20000) @(posedge MCLK);
        num_errors++;
        close_out;
    end

    initial begin
        SYS_RST = 1;
        PSEL = 0;
        PENABLE = 0;
        PWRITE = 0;
        PADDR = '0;
        PWDATA = '0;
        repeat (16) @(posedge MCLK);
        chk(BARS, BARS_RST);
        SYS_RST <= 0;
        repeat (2) @(posedge MCLK);
        apb(0, CTRL_OFS, 0);
        chk(err, 0);
        chk(rd, {28'h0, CTRL_RST});
        // Table rows back to back, so the buffer fills
        foreach (rows[i]) push(rows[i].code, rows[i].pos);
        drain;
        chk(full_seen, 1);
        // Case change with a slow selector
        sel.gap = 3;
        push(SYMBOL_CODE, 5'h1B);
        push(5'h00, 5'h00);
        push(ALPHA_CODE, 5'h1F);
        push(5'h00, 5'h00);
        drain;
        sel.gap = 0;
        // Function only state with the shift and return-and-feed bars set, suppression clear
        ctrl_now = 4'h7;
        apb(1, CTRL_OFS, 32'h7);
        push(5'h03, 5'h18);
        drain;
        apb(0, STAT_OFS, 0);
        chk(rd, 32'h000031A3);
        ctrl_now = 4'h8;
        apb(1, CTRL_OFS, 32'h8);
        chk(nfunc, npush);
        chk(nprint, nexp_print);
        apb(0, COUNT_OFS, 0);
        chk(rd, nexp_print);
        apb(1, COUNT_OFS, 0);
        apb(0, COUNT_OFS, 0);
        chk(rd, 0);
        apb(0, 12'h00C, 0);
        chk(err, 1);
        chk(rd, 32'h0);
        // Reset after a symbol change, with the decoder idle, returns the alpha half
        push(SYMBOL_CODE, 5'h1B);
        drain;
        SYS_RST <= 1;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 0;
        repeat (2) @(posedge MCLK);
        chk(BARS, BARS_RST);
        half_exp = 0;
        push(5'h00, 5'h00);
        drain;
        close_out;
    end
endmodule : test_character_position_decoder
